// >>> pkg/ivc_pkg.sv
// Shared constants, types and helpers for the interval counter channel
package ivc_pkg;

    // Counter and bus widths
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;

    // Read/load byte format field values
    localparam logic [1:0] FMT_LSB = 2'h1;
    localparam logic [1:0] FMT_MSB = 2'h2;
    localparam logic [1:0] FMT_BOTH = 2'h3;

    // Reset values and count step constants
    localparam logic [1:0] FMT_RST = 2'h3;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_TWO = 16'h0002;
    localparam logic WAVE_RST = 1'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Operating modes
    typedef enum logic [2:0] {
        M_TC,
        M_ONE,
        M_RATE,
        M_SQ,
        M_SSTB,
        M_HSTB
    } ivc_mode_t;

    // Host request carrier, all fields one-cycle strobes or data
    typedef struct packed {
        logic ctrl_wr;
        logic [2:0] mode;
        logic [1:0] read_load_format_field;
        logic latch;
        logic wr;
        logic rd;
        logic [7:0] data;
    } ivc_host_t;

    // Three-bit mode code to mode; bit 2 is a don't-care for 2 and 3
    function automatic ivc_mode_t ivc_decode(input logic [2:0] code);
        ivc_mode_t m;
        m = M_TC;
        if (code[1]) begin
            m = code[0] ? M_SQ : M_RATE;
        end else begin
            case ({code[2], code[0]})
                2'h0: m = M_TC;
                2'h1: m = M_ONE;
                2'h2: m = M_SSTB;
                default: m = M_HSTB;
            endcase
        end
        return m;
    endfunction : ivc_decode

endpackage : ivc_pkg

// >>> logic/ivc_sync.sv
// Two-stage synchroniser with rising edge detect for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ivc_sync #(
    parameter int W = 2
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [W-1:0] PIN_IN,
    output logic [W-1:0] LEVEL_OUT,
    output logic [W-1:0] RISE_OUT
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // Two flops, then one more stage for edge history
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= PIN_IN;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Level and one-cycle rising pulse
    assign LEVEL_OUT = sync_r;
    assign RISE_OUT = sync_r & ~prev_r;
endmodule : ivc_sync
`default_nettype wire

// >>> logic/ivc_readout.sv
// Count read path: latch command holding register and byte sequencer
`timescale 1ns/1ps
`default_nettype none
module ivc_readout
    import ivc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CTRL_WR_IN,
    input wire logic [1:0] FMT_IN,
    input wire logic LATCH_IN,
    input wire logic RD_IN,
    input wire logic VALID_IN,
    input wire logic [15:0] COUNT_IN,
    output logic [7:0] RDATA_OUT
);
    logic held_r;
    logic [15:0] hold_r;
    logic msb_next_r;
    logic [15:0] src;
    logic last_byte;
    logic take_rd;

    // Byte chosen by the format and position in a two-byte read
    function automatic logic [7:0] pick(input logic [15:0] v,
                                        input logic [1:0] f,
                                        input logic msb);
        logic [7:0] b;
        b = v[7:0];
        if (f == FMT_MSB || (f == FMT_BOTH && msb)) begin
            b = v[15:8];
        end
        return b;
    endfunction : pick

    // Held value if latched, else the live count
    assign src = held_r ? hold_r : COUNT_IN;
    assign take_rd = RD_IN && VALID_IN;
    assign last_byte = (FMT_IN != FMT_BOTH) || msb_next_r;

    // Latch capture and release after the full read
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || CTRL_WR_IN) begin
            held_r <= 1'h0;
            hold_r <= CNT_RST;
        end else if (LATCH_IN && !held_r) begin
            held_r <= 1'h1;
            hold_r <= COUNT_IN;
        end else if (take_rd && last_byte && held_r) begin
            held_r <= 1'h0;
        end
    end

    // Byte order pointer for two-byte reads
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || CTRL_WR_IN) begin
            msb_next_r <= 1'h0;
        end else if (take_rd && FMT_IN == FMT_BOTH) begin
            msb_next_r <= ~msb_next_r;
        end
    end

    // Registered read data
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            RDATA_OUT <= BYTE_ZERO;
        end else if (take_rd) begin
            RDATA_OUT <= pick(src, FMT_IN, msb_next_r);
        end
    end
endmodule : ivc_readout
`default_nettype wire

// >>> logic/ivc_counter.sv
// One 16-bit down-counter channel of a programmable interval timer
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Mode 0 two-byte write: low byte halts counting, high byte resumes.
// - Mode 1: output high on programming; a count write alone starts nothing.
// - Mode 1: gate rise triggers; output low next tick, high at terminal.
// - Mode 1: a started one-shot runs to terminal despite a low gate.
// - Mode 1: new count leaves interval alone; next trigger uses it.
// - Mode 2: output high; start next tick if gate high, else gate rise.
// - Mode 2: one-tick low pulse once every n ticks, repeating.
// - Mode 2: new count applies after the current period completes.
// - Modes 2, 3: low gate stops and forces output high; rise restarts.
// - Mode 3: square wave period n; odd n high (n+1)/2, low (n-1)/2.
// - Mode 3: new count applies after the next output transition.
// - Mode 3 starts and uses the gate exactly as mode 2.
// - Mode 4: output high, start as mode 0, one low tick at terminal.
// - Mode 4: low gate stops; gate return restarts from full count.
// - Mode 5: gate rise starts or retriggers; output as mode 4.
// - Count down by one per tick, by two in mode 3.
// - Latch command captures the count without disturbing counting.
// - Mode 0 starts once count fully written with gate high; low gate holds.
// - Control word clears the count; reads are ignored until a count is written.
module ivc_counter
    import ivc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire ivc_host_t HOST_IN,
    input wire logic CNT_CLK_IN,
    input wire logic GATE_IN,
    output logic WAVE_OUT,
    output logic [7:0] RDATA_OUT
);
    ivc_mode_t mode_r;
    logic [1:0] fmt_r;
    logic [15:0] init_r;
    logic [7:0] lo_r;
    logic lsb_wait_r;
    logic pend_r;
    logic have_r;
    logic trig_r;
    logic [15:0] cnt_r;
    logic run_r;
    logic out_r;
    logic [1:0] lvl;
    logic [1:0] rise;
    logic tick;
    logic gate_s;
    logic gate_rise;
    logic periodic;
    logic hold_cnt;
    logic at_one;
    logic at_two;

    // Half-period reload for the square wave
    function automatic logic [15:0] sq_load(input logic [15:0] n,
                                            input logic high);
        logic [15:0] v;
        v = n;
        if (n[0]) begin
            v = high ? 16'(n + CNT_ONE) : 16'(n - CNT_ONE);
        end
        return v;
    endfunction : sq_load

    // One down-count step; wraps so that a count of zero runs 65536 ticks
    function automatic logic [15:0] step_down(input logic [15:0] v,
                                              input logic [15:0] by);
        logic [15:0] d;
        d = 16'(v - by);
        return d;
    endfunction : step_down

    // Count clock and gate pins into this domain
    ivc_sync #(
        .W(2)
    ) u_sync (
        .CLK_IN(CLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .PIN_IN({GATE_IN, CNT_CLK_IN}),
        .LEVEL_OUT(lvl),
        .RISE_OUT(rise)
    );

    // Tick enable and gate views
    assign tick = rise[0];
    assign gate_s = lvl[1];
    assign gate_rise = rise[1];
    assign periodic = (mode_r == M_RATE) || (mode_r == M_SQ);
    // Mode 0 halted while a new count is being written
    assign hold_cnt = (mode_r == M_TC) && (lsb_wait_r || pend_r);
    // Terminal and next-to-terminal count views
    assign at_one = (cnt_r == CNT_ONE);
    assign at_two = (cnt_r == CNT_TWO);

    // Mode taken from the control word
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_r <= M_TC;
        end else if (HOST_IN.ctrl_wr) begin
            mode_r <= ivc_decode(HOST_IN.mode);
        end
    end

    // Read/load byte format taken from the control word
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            fmt_r <= FMT_RST;
        end else if (HOST_IN.ctrl_wr) begin
            fmt_r <= HOST_IN.read_load_format_field;
        end
    end

    // Count value assembly by format
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            init_r <= CNT_RST;
            lo_r <= BYTE_ZERO;
            lsb_wait_r <= 1'h0;
            pend_r <= 1'h0;
            have_r <= 1'h0;
        end else if (HOST_IN.ctrl_wr) begin
            lsb_wait_r <= 1'h0;
            pend_r <= 1'h0;
            have_r <= 1'h0;
        end else if (HOST_IN.wr) begin
            // Halves of a two-byte count are paired low then high
            unique case (fmt_r)
                FMT_LSB: begin
                    init_r <= {BYTE_ZERO, HOST_IN.data};
                    pend_r <= 1'h1;
                    have_r <= 1'h1;
                end
                FMT_MSB: begin
                    init_r <= {HOST_IN.data, BYTE_ZERO};
                    pend_r <= 1'h1;
                    have_r <= 1'h1;
                end
                default: begin
                    if (!lsb_wait_r) begin
                        lo_r <= HOST_IN.data;
                        lsb_wait_r <= 1'h1;
                    end else begin
                        init_r <= {HOST_IN.data, lo_r};
                        lsb_wait_r <= 1'h0;
                        pend_r <= 1'h1;
                        have_r <= 1'h1;
                    end
                end
            endcase
        end else if (tick) begin
            // The pending load is consumed by the core on this tick
            pend_r <= 1'h0;
        end
    end

    // Gate rise held until the next tick; a new rise wins over clear
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || HOST_IN.ctrl_wr) begin
            trig_r <= 1'h0;
        end else if (gate_rise) begin
            trig_r <= 1'h1;
        end else if (tick) begin
            trig_r <= 1'h0;
        end
    end

    // Counting core and output waveform
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            cnt_r <= CNT_RST;
            run_r <= 1'h0;
            out_r <= WAVE_RST;
        end else if (HOST_IN.ctrl_wr) begin
            cnt_r <= CNT_RST;
            run_r <= 1'h0;
            // Mode 0 starts low, all others high
            out_r <= (ivc_decode(HOST_IN.mode) != M_TC);
        end else if (periodic && !gate_s) begin
            // Low gate stops modes 2 and 3 at once, not on a tick
            run_r <= 1'h0;
            out_r <= 1'h1;
        end else if (tick) begin
            unique case (mode_r)
                // Software-started modes: load once the count is complete
                M_TC, M_SSTB: begin
                    if (pend_r) begin
                        cnt_r <= init_r;
                        run_r <= 1'h1;
                        // Mode 0 output drops as the new count loads
                        if (mode_r == M_TC) begin
                            out_r <= 1'h0;
                        end
                    end else if (mode_r == M_SSTB && trig_r && run_r) begin
                        cnt_r <= init_r;
                    end else begin
                        // Strobe low lasts exactly one tick
                        if (mode_r == M_SSTB && !out_r) begin
                            out_r <= 1'h1;
                        end
                        // A low gate, or in mode 0 a half-written count, holds the value
                        if (run_r && gate_s && !hold_cnt) begin
                            cnt_r <= step_down(cnt_r, CNT_ONE);
                            if (at_one) begin
                                if (mode_r == M_TC) begin
                                    out_r <= 1'h1;
                                end else begin
                                    out_r <= 1'h0;
                                    run_r <= 1'h0;
                                end
                            end
                        end
                    end
                end

                // Gate-triggered modes: a latched gate rise loads the count
                M_ONE, M_HSTB: begin
                    if (trig_r && have_r) begin
                        // Retrigger restarts from the latest written count
                        cnt_r <= init_r;
                        run_r <= 1'h1;
                        if (mode_r == M_ONE) begin
                            out_r <= 1'h0;
                        end
                    end else begin
                        if (mode_r == M_HSTB && !out_r) begin
                            out_r <= 1'h1;
                        end
                        // Runs to terminal whatever the gate does meanwhile
                        if (run_r) begin
                            cnt_r <= step_down(cnt_r, CNT_ONE);
                            if (at_one) begin
                                run_r <= 1'h0;
                                out_r <= (mode_r == M_ONE);
                            end
                        end
                    end
                end

                // Rate generator: low for the last tick of each period
                M_RATE: begin
                    if (!run_r) begin
                        // Stopped: restart from the programmed count
                        if (have_r) begin
                            cnt_r <= init_r;
                            run_r <= 1'h1;
                            out_r <= 1'h1;
                        end
                    end else if (at_two) begin
                        cnt_r <= CNT_ONE;
                        out_r <= 1'h0;
                    end else if (at_one) begin
                        cnt_r <= init_r;
                        out_r <= 1'h1;
                    end else begin
                        cnt_r <= step_down(cnt_r, CNT_ONE);
                    end
                end

                // Square wave: two per tick, reload at each half period
                M_SQ: begin
                    if (!run_r) begin
                        // Odd counts start one longer on the high half
                        if (have_r) begin
                            cnt_r <= sq_load(init_r, 1'h1);
                            run_r <= 1'h1;
                            out_r <= 1'h1;
                        end
                    end else if (at_two) begin
                        // New count takes effect from this transition
                        out_r <= ~out_r;
                        cnt_r <= sq_load(init_r, ~out_r);
                    end else begin
                        cnt_r <= step_down(cnt_r, CNT_TWO);
                    end
                end
            endcase
        end
    end

    // Output straight from its flop
    assign WAVE_OUT = out_r;

    // Read path with latch command support
    ivc_readout u_readout (
        .CLK_IN(CLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .CTRL_WR_IN(HOST_IN.ctrl_wr),
        .FMT_IN(fmt_r),
        .LATCH_IN(HOST_IN.latch),
        .RD_IN(HOST_IN.rd),
        .VALID_IN(have_r),
        .COUNT_IN(cnt_r),
        .RDATA_OUT(RDATA_OUT)
    );
endmodule : ivc_counter
`default_nettype wire

// >>> verif/ivc_counter_sva.sv
// Port-level assertions for the interval counter channel
`timescale 1ns/1ps
`default_nettype none
module ivc_counter_sva
    import ivc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire ivc_host_t HOST_IN,
    input wire logic CNT_CLK_IN,
    input wire logic GATE_IN,
    input wire logic WAVE_OUT,
    input wire logic [7:0] RDATA_OUT
);
    logic [2:0] mode_r;
    logic fresh_r;
    logic clk_d_r;
    logic gate_d_r;
    logic [4:0] clk_age_r;
    logic [4:0] gate_age_r;
    // Mode classes of the last control word
    wire m23 = mode_r[1];
    wire m1 = (mode_r == 3'h1);
    wire mstb = (mode_r[2:1] == 2'h2);

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // Last mode code; fresh until a count byte follows
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_r <= 3'h0;
            fresh_r <= 1'b0;
        end else if (HOST_IN.ctrl_wr) begin
            mode_r <= HOST_IN.mode;
            fresh_r <= 1'b1;
        end else if (HOST_IN.wr) begin
            fresh_r <= 1'b0;
        end
    end

    // Cycles since the last raw rise of count clock and gate
    always_ff @(posedge CLK_IN) begin
        clk_d_r <= CNT_CLK_IN;
        gate_d_r <= GATE_IN;
        if (SYS_RST_IN) begin
            clk_age_r <= 5'h1f;
            gate_age_r <= 5'h1f;
        end else begin
            clk_age_r <= (CNT_CLK_IN && !clk_d_r) ? 5'h00
                : clk_age_r + {4'h0, clk_age_r != 5'h1f};
            gate_age_r <= (GATE_IN && !gate_d_r) ? 5'h00
                : gate_age_r + {4'h0, gate_age_r != 5'h1f};
        end
    end

    reset_out_a:
        assert property (disable iff (1'b0) SYS_RST_IN |=>
            WAVE_OUT && RDATA_OUT == 8'h00)
        else $error("outputs not at reset values");
    prog_high_a:
        assert property (HOST_IN.ctrl_wr && HOST_IN.mode != 3'h0 |=> WAVE_OUT)
        else $error("output not high after programming");
    rd_hold_a:
        assert property (!HOST_IN.rd |=> $stable(RDATA_OUT))
        else $error("read data moved without a read");
    fresh_rd_a:
        assert property (fresh_r && HOST_IN.rd |=> $stable(RDATA_OUT))
        else $error("cleared count was readable");
    gate_force_a:
        assert property ((m23 && !GATE_IN) [*5] |-> WAVE_OUT)
        else $error("low gate did not force output high");
    strobe_pulse_a:
        assert property (mstb && $fell(WAVE_OUT) |->
            !WAVE_OUT [*6] ##[1:20] WAVE_OUT)
        else $error("strobe pulse not one count clock");
    tick_edge_a:
        assert property ((m1 || mstb) && $changed(WAVE_OUT)
            && !$past(HOST_IN.ctrl_wr) |-> clk_age_r inside {[5'h01:5'h07]})
        else $error("output moved away from a count clock");
    trig_fall_a:
        assert property (m1 && $fell(WAVE_OUT) |-> gate_age_r <= 5'h14)
        else $error("one-shot started without a gate rise");
endmodule : ivc_counter_sva
`default_nettype wire

// >>> verif/ivc_host_model.sv
// Host processor model: control words, count bytes, latch, reads
`timescale 1ns/1ps
`default_nettype none
module ivc_host_model
    import ivc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic [7:0] RDATA_IN,
    output var ivc_host_t HOST_OUT
);
    // Idle bus from time zero
    initial HOST_OUT = '0;

    // One-cycle request launched just after a rising edge
    task automatic pulse(input ivc_host_t v);
        @(posedge CLK_IN);
        HOST_OUT <= v;
        @(posedge CLK_IN);
        HOST_OUT <= '0;
    endtask : pulse

    // Request kinds, each built field by field from an idle bus
    task automatic ctrl(input logic [2:0] m, input logic [1:0] f);
        ivc_host_t v;
        v = '0;
        v.ctrl_wr = 1'b1;
        v.mode = m;
        v.read_load_format_field = f;
        pulse(v);
    endtask : ctrl
    task automatic wr(input logic [7:0] d);
        ivc_host_t v;
        v = '0;
        v.wr = 1'b1;
        v.data = d;
        pulse(v);
    endtask : wr
    task automatic latch();
        ivc_host_t v;
        v = '0;
        v.latch = 1'b1;
        pulse(v);
    endtask : latch

    // Read one byte once the answer has settled
    task automatic get(output logic [7:0] b);
        ivc_host_t v;
        v = '0;
        v.rd = 1'b1;
        pulse(v);
        @(posedge CLK_IN);
        @(negedge CLK_IN);
        b = RDATA_IN;
    endtask : get
    // Two-byte read, low byte first
    task automatic get16(output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        get(lo);
        get(hi);
        w = {hi, lo};
    endtask : get16
endmodule : ivc_host_model
`default_nettype wire

// >>> verif/ivc_counter_test.sv
// Self-checking bench for the interval counter channel
`timescale 1ns/1ps
`default_nettype none
module ivc_counter_test
    import ivc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cnt_clk = 1'b0;
    logic gate = 1'b0;
    logic wave;
    logic [7:0] rdata;
    ivc_host_t host;
    int n_fail = 0;
    int n_tests = 0;
    logic [15:0] k;
    logic [15:0] v;
    logic [7:0] b;

    // System clock, 10 ns
    always #5 clk = ~clk;

    ivc_host_model host_m (.CLK_IN(clk), .RDATA_IN(rdata), .HOST_OUT(host));
    ivc_counter dut (.CLK_IN(clk), .SYS_RST_IN(rst), .HOST_IN(host),
        .CNT_CLK_IN(cnt_clk), .GATE_IN(gate), .WAVE_OUT(wave),
        .RDATA_OUT(rdata));

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cw(input logic e);
        @(negedge clk);
        check({15'h0000, wave}, {15'h0000, e});
    endtask : cw
    // Count clock pulses, five cycles high and five low
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            cnt_clk <= 1'b1;
            repeat (5) @(posedge clk);
            cnt_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : tick
    // Gate level, then time for the synchroniser
    task automatic gset(input logic g);
        @(posedge clk);
        gate <= g;
        repeat (5) @(posedge clk);
    endtask : gset
    // Ticks until the output leaves the given level
    task automatic run(input logic lvl, output logic [15:0] n);
        n = 16'h0000;
        do begin
            tick(1);
            @(negedge clk);
            n++;
        end while (wave === lvl && n < 16'h0040);
    endtask : run

    task automatic s_mode0();
        gset(1'b1);
        host_m.ctrl(3'h0, FMT_BOTH);
        host_m.wr(8'h0a);
        host_m.wr(8'h01);
        tick(3);
        host_m.latch();
        host_m.get16(v);
        check(v, 16'h0108);
        host_m.wr(8'h20);
        tick(3);
        host_m.latch();
        host_m.get16(v);
        check(v, 16'h0108);
        host_m.wr(8'h01);
        tick(3);
        host_m.latch();
        tick(2);
        host_m.latch();
        host_m.get16(v);
        check(v, 16'h011e);
        gset(1'b0);
        tick(2);
        host_m.get16(v);
        check(v, 16'h011c);
        host_m.ctrl(3'h0, FMT_MSB);
        cw(1'b0);
        gset(1'b1);
        host_m.wr(8'h02);
        tick(3);
        host_m.latch();
        host_m.get(b);
        check({8'h00, b}, 16'h0001);
    endtask : s_mode0

    task automatic s_mode4();
        gset(1'b1);
        host_m.ctrl(3'h4, FMT_LSB);
        cw(1'b1);
        host_m.get(b);
        check({8'h00, b}, 16'h0001);
        host_m.wr(8'h03);
        run(1'b1, k);
        check(k, 16'h0004);
        run(1'b0, k);
        check(k, 16'h0001);
        tick(5);
        cw(1'b1);
        host_m.wr(8'h03);
        tick(2);
        gset(1'b0);
        tick(3);
        cw(1'b1);
        gset(1'b1);
        run(1'b1, k);
        check(k, 16'h0004);
        run(1'b0, k);
    endtask : s_mode4

    task automatic s_mode1();
        gset(1'b0);
        host_m.ctrl(3'h1, FMT_LSB);
        cw(1'b1);
        host_m.wr(8'h03);
        tick(3);
        cw(1'b1);
        gset(1'b1);
        run(1'b1, k);
        check(k, 16'h0001);
        gset(1'b0);
        host_m.wr(8'h05);
        run(1'b0, k);
        check(k, 16'h0003);
        gset(1'b1);
        run(1'b1, k);
        run(1'b0, k);
        check(k, 16'h0005);
    endtask : s_mode1

    task automatic s_mode23();
        host_m.ctrl(3'h6, FMT_LSB);
        cw(1'b1);
        host_m.wr(8'h03);
        run(1'b1, k);
        check(k, 16'h0003);
        run(1'b0, k);
        check(k, 16'h0001);
        run(1'b1, k);
        check(k, 16'h0002);
        run(1'b0, k);
        host_m.wr(8'h05);
        run(1'b1, k);
        check(k, 16'h0002);
        run(1'b0, k);
        run(1'b1, k);
        check(k, 16'h0004);
        gset(1'b0);
        cw(1'b1);
        tick(3);
        gset(1'b1);
        run(1'b1, k);
        check(k, 16'h0005);
        host_m.ctrl(3'h3, FMT_LSB);
        cw(1'b1);
        host_m.wr(8'h05);
        run(1'b1, k);
        run(1'b0, k);
        check(k, 16'h0002);
        run(1'b1, k);
        check(k, 16'h0003);
        host_m.wr(8'h04);
        run(1'b0, k);
        run(1'b1, k);
        check(k, 16'h0002);
        gset(1'b0);
        cw(1'b1);
    endtask : s_mode23

    task automatic s_mode5();
        host_m.ctrl(3'h5, FMT_LSB);
        host_m.wr(8'h02);
        tick(3);
        cw(1'b1);
        gset(1'b1);
        tick(1);
        gset(1'b0);
        gset(1'b1);
        run(1'b1, k);
        check(k, 16'h0003);
        run(1'b0, k);
        check(k, 16'h0001);
    endtask : s_mode5

    // Counts, verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cw(1'b1);
        check({8'h00, rdata}, 16'h0000);
        repeat (3) @(posedge clk);
        s_mode0();
        s_mode4();
        s_mode1();
        s_mode23();
        s_mode5();
        results();
    end

    // Watchdog against a hang
    initial begin
        #400000;
        n_fail++;
        results();
    end
endmodule : ivc_counter_test

bind ivc_counter ivc_counter_sva chk (.CLK_IN(CLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .HOST_IN(HOST_IN), .CNT_CLK_IN(CNT_CLK_IN),
    .GATE_IN(GATE_IN), .WAVE_OUT(WAVE_OUT), .RDATA_OUT(RDATA_OUT));
`default_nettype wire
